/* File: src/br4k_ram.sv */
// 4 kbit block ram with sampled write and read ports
`timescale 1ns/100ps
module br4k_ram #(
    parameter logic [4095:0] INIT_CONTENT = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] ram_shape,
    input wire logic [1:0] edge_mode,
    input wire logic wr_clk,
    input wire logic wr_clk_qualify,
    input wire logic wr_allow,
    input wire logic [10:0] wr_location,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] wr_mask,
    input wire logic rd_clk,
    input wire logic rd_clk_qualify,
    input wire logic rd_allow,
    input wire logic [10:0] rd_location,
    output logic [15:0] rd_data,
    output logic init_done
);
    // row of the 256x16 array that holds a word
    function automatic logic [7:0] row_of(logic [1:0] s, logic [10:0] a);
        case (s)
            br4k_pkg::SHAPE_X16: row_of = a[7:0];
            br4k_pkg::SHAPE_X8: row_of = a[8:1];
            br4k_pkg::SHAPE_X4: row_of = a[9:2];
            default: row_of = a[10:3];
        endcase
    endfunction : row_of

    // bit offset of a word inside its row
    function automatic logic [3:0] shift_of(logic [1:0] s,
                                            logic [10:0] a);
        case (s)
            br4k_pkg::SHAPE_X16: shift_of = 4'h0;
            br4k_pkg::SHAPE_X8: shift_of = {a[0], 3'b000};
            br4k_pkg::SHAPE_X4: shift_of = {a[1:0], 2'b00};
            default: shift_of = {a[2:0], 1'b0};
        endcase
    endfunction : shift_of

    // bits used by one word of the shape
    function automatic logic [15:0] width_of(logic [1:0] s);
        case (s)
            br4k_pkg::SHAPE_X16: width_of = 16'hffff;
            br4k_pkg::SHAPE_X8: width_of = 16'h00ff;
            br4k_pkg::SHAPE_X4: width_of = 16'h000f;
            default: width_of = 16'h0003;
        endcase
    endfunction : width_of

    // word pulled out of a row
    function automatic logic [15:0] extract(logic [1:0] s,
                                            logic [10:0] a,
                                            logic [15:0] r);
        extract = (r >> shift_of(s, a)) & width_of(s);
    endfunction : extract

    // input synchronisers: first stage feeds only the second
    logic [45:0] wr_s1_q, wr_s2_q;
    logic [13:0] rd_s1_q, rd_s2_q;
    logic [3:0] cfg_s1_q, cfg_s2_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_s1_q <= '0;
            wr_s2_q <= '0;
            rd_s1_q <= '0;
            rd_s2_q <= '0;
            cfg_s1_q <= '0;
            cfg_s2_q <= '0;
        end else begin
            wr_s1_q <= {wr_clk, wr_clk_qualify, wr_allow, wr_location,
                        wr_data, wr_mask};
            wr_s2_q <= wr_s1_q;
            rd_s1_q <= {rd_clk, rd_clk_qualify, rd_allow, rd_location};
            rd_s2_q <= rd_s1_q;
            cfg_s1_q <= {ram_shape, edge_mode};
            cfg_s2_q <= cfg_s1_q;
        end
    end

    logic [1:0] shape;
    logic [1:0] emode;
    logic wclk_s, wqual_s, wallow_s, rclk_s, rqual_s, rallow_s;
    logic [10:0] wloc_s, rloc_s;
    logic [15:0] wdata_s, wmask_s;
    assign shape = cfg_s2_q[3:2];
    assign emode = cfg_s2_q[1:0];
    assign {wclk_s, wqual_s, wallow_s, wloc_s, wdata_s, wmask_s} = wr_s2_q;
    assign {rclk_s, rqual_s, rallow_s, rloc_s} = rd_s2_q;

    // previous port clock levels for edge detection
    logic wclk_prev_q, rclk_prev_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end else begin
            wclk_prev_q <= wclk_s;
            rclk_prev_q <= rclk_s;
        end
    end

    // both write qualifiers must be high for a write
    function automatic logic wr_allow_ok(logic al, logic ql);
        wr_allow_ok = al & ql;
    endfunction : wr_allow_ok

    // active edge per variant
    logic wr_rise, wr_fall, rd_rise, rd_fall, wr_inv, rd_inv;
    logic wr_edge, rd_edge, wr_go, rd_go;
    assign wr_rise = wclk_s & ~wclk_prev_q;
    assign wr_fall = ~wclk_s & wclk_prev_q;
    assign rd_rise = rclk_s & ~rclk_prev_q;
    assign rd_fall = ~rclk_s & rclk_prev_q;
    assign wr_inv = emode[1]; // [RULE7] [RULE8]
    assign rd_inv = emode[0]; // [RULE6] [RULE8]
    assign wr_edge = wr_inv ? wr_fall : wr_rise; // [RULE5]
    assign rd_edge = rd_inv ? rd_fall : rd_rise; // [RULE5]
    assign wr_go = wr_edge & wr_allow_ok(wallow_s, wqual_s); // [RULE10]
    assign rd_go = rd_edge & rallow_s & rqual_s; // [RULE11]

    // preload sweep walks every row before user operation
    br4k_pkg::br4k_init_t init_q;
    logic [7:0] init_cnt_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_q <= br4k_pkg::INIT_SWEEP;
            init_cnt_q <= 8'h00;
        end else begin
            case (init_q)
                br4k_pkg::INIT_SWEEP: begin
                    init_cnt_q <= init_cnt_q + 8'h01;
                    if (init_cnt_q == br4k_pkg::INIT_LAST) begin
                        init_q <= br4k_pkg::INIT_DONE; // [RULE12]
                    end
                end
                default: init_cnt_q <= init_cnt_q;
            endcase
        end
    end
    assign init_done = (init_q == br4k_pkg::INIT_DONE);

    // write port input registers at the array
    logic wr_pend_q;
    logic [7:0] wr_row_q;
    logic [15:0] wr_bits_q, wr_word_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_row_q <= 8'h00;
            wr_bits_q <= 16'h0000;
            wr_word_q <= 16'h0000;
        end else begin
            wr_pend_q <= wr_go & init_done; // [RULE10] [RULE12]
            if (wr_go) begin
                wr_row_q <= row_of(shape, wloc_s); // [RULE9] [RULE3]
                wr_word_q <= (wdata_s & width_of(shape))
                             << shift_of(shape, wloc_s); // [RULE9]
                // only the 16-bit shape honours the mask
                wr_bits_q <= (width_of(shape) << shift_of(shape, wloc_s))
                             & ((shape == br4k_pkg::SHAPE_X16)
                                ? ~wmask_s : 16'hffff); // [RULE4]
            end
        end
    end

    // storage array, no reset; preload then masked writes
    logic [15:0] mem_q [br4k_pkg::ROWS];
    always_ff @(posedge sys_clk) begin
        if (!init_done) begin
            mem_q[init_cnt_q] <=
                INIT_CONTENT[{init_cnt_q, 4'h0} +: 16]; // [RULE12]
        end else if (wr_pend_q) begin
            mem_q[wr_row_q] <= (mem_q[wr_row_q] & ~wr_bits_q)
                               | (wr_word_q & wr_bits_q); // [RULE2] [RULE4]
        end
    end

    // read port address register and output register
    logic rd_pend_q;
    logic [10:0] rd_loc_q;
    logic [1:0] rd_shape_q;
    logic [15:0] rd_data_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_q <= 1'b0;
            rd_loc_q <= 11'h000;
            rd_shape_q <= 2'b00;
            rd_data_q <= br4k_pkg::RD_DATA_RST;
        end else begin
            rd_pend_q <= rd_go & init_done; // [RULE11]
            if (rd_go) begin
                rd_loc_q <= rloc_s; // [RULE9]
                rd_shape_q <= shape;
            end
            if (rd_pend_q) begin
                // holds between qualified reads
                rd_data_q <= extract(rd_shape_q, rd_loc_q,
                    mem_q[row_of(rd_shape_q, rd_loc_q)]); // [RULE15] [RULE1]
            end
        end
    end
    assign rd_data = rd_data_q;

    // checks
    // write address is taken into the array input register
    wr_capture_a: assert property ( // [RULE9]
        @(posedge sys_clk) disable iff (!rst_n)
        wr_go && init_done |=> wr_pend_q
            && wr_row_q == row_of($past(shape), $past(wloc_s)))
        else $error("write not captured at array input");
    // no write unless both write qualifiers meet an active edge
    wr_qualify_a: assert property ( // [RULE10]
        @(posedge sys_clk) disable iff (!rst_n)
        !(wr_edge && wallow_s && wqual_s) |=> !wr_pend_q)
        else $error("write without both write enables");

    // no read unless both read qualifiers meet an active edge
    rd_qualify_a: assert property ( // [RULE11]
        @(posedge sys_clk) disable iff (!rst_n)
        !(rd_edge && rallow_s && rqual_s) |=> !rd_pend_q)
        else $error("read without both read enables");
    // read address and shape are registered on the read edge
    rd_capture_a: assert property ( // [RULE9]
        @(posedge sys_clk) disable iff (!rst_n)
        rd_go |=> rd_loc_q == $past(rloc_s)
            && rd_shape_q == $past(shape))
        else $error("read address not captured at array input");
    // output register holds between qualified reads
    rd_hold_a: assert property ( // [RULE15]
        @(posedge sys_clk) disable iff (!rst_n)
        !rd_pend_q |=> $stable(rd_data_q))
        else $error("read data moved without a read");
    // unused upper data bits stay zero
    rd_value_a: assert property ( // [RULE3]
        @(posedge sys_clk) disable iff (!rst_n)
        rd_pend_q |=> (rd_data_q & ~width_of($past(rd_shape_q))) == 16'h0)
        else $error("read data wider than word");

    // default variant ignores falling edges on both ports
    rise_default_a: assert property ( // [RULE5]
        @(posedge sys_clk) disable iff (!rst_n)
        emode == br4k_pkg::EDGE_RISING && (wr_fall || rd_fall)
            |=> !wr_pend_q && !rd_pend_q)
        else $error("default variant used falling edge");
    // read inverted variant ignores a rising read edge
    rd_inverted_a: assert property ( // [RULE6]
        @(posedge sys_clk) disable iff (!rst_n)
        emode == br4k_pkg::EDGE_RD_INVERTED && rd_rise |=> !rd_pend_q)
        else $error("read inverted variant read on rising");
    // write inverted variant ignores a rising write edge
    wr_inverted_a: assert property ( // [RULE7]
        @(posedge sys_clk) disable iff (!rst_n)
        emode == br4k_pkg::EDGE_WR_INVERTED && wr_rise |=> !wr_pend_q)
        else $error("write inverted variant wrote on rising");
    // fully inverted variant ignores rising edges on both ports
    both_inverted_a: assert property ( // [RULE8]
        @(posedge sys_clk) disable iff (!rst_n)
        emode == br4k_pkg::EDGE_BOTH_INVERTED && (wr_rise || rd_rise)
            |=> !wr_pend_q && !rd_pend_q)
        else $error("inverted variant used rising edge");

    // bits outside the write lanes or masked stay as they were
    mask_keep_a: assert property ( // [RULE4]
        @(posedge sys_clk) disable iff (!rst_n)
        wr_pend_q |=> ((mem_q[$past(wr_row_q)] ^ $past(mem_q[wr_row_q]))
            & ~$past(wr_bits_q)) == 16'h0)
        else $error("masked bit changed");
    // enabled bits take the new data
    mask_write_a: assert property ( // [RULE4]
        @(posedge sys_clk) disable iff (!rst_n)
        wr_pend_q |=> ((mem_q[$past(wr_row_q)] ^ $past(wr_word_q))
            & $past(wr_bits_q)) == 16'h0)
        else $error("enabled bit not written");

    // preload sweep ends after its last row
    init_end_a: assert property ( // [RULE12]
        @(posedge sys_clk) disable iff (!rst_n)
        !init_done && init_cnt_q == br4k_pkg::INIT_LAST |=> init_done)
        else $error("preload sweep did not finish");
    // preload sweep visits each row in turn
    init_step_a: assert property ( // [RULE12]
        @(posedge sys_clk) disable iff (!rst_n)
        !init_done |=> init_cnt_q == $past(init_cnt_q) + 8'h01)
        else $error("preload sweep skipped a row");
    // user accesses are dropped while the sweep runs
    init_block_a: assert property ( // [RULE12]
        @(posedge sys_clk) disable iff (!rst_n)
        !init_done |=> !rd_pend_q && (!wr_pend_q || $past(init_done)))
        else $error("access during preload");

    // main scenarios reached
    write_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        wr_pend_q);
    read_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        rd_pend_q ##1 !rd_pend_q);
    masked_write_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        wr_pend_q && wr_bits_q != 16'hffff && shape == 2'b00);
    preload_done_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(init_done));
    inverted_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        rd_pend_q && emode == br4k_pkg::EDGE_BOTH_INVERTED);
endmodule : br4k_ram

/* File: src/br4k_pkg.sv */
// package of constants and types for the 4 kbit block ram
// Function
// RULE1 - serves single port, dual port, fifo storage
// RULE2 - 4 kbit as 256x16, 512x8, 1024x4, 2048x2
// RULE3 - address and data widths follow chosen shape
// RULE4 - 16-bit shape only: mask bit 1 keeps bit
// RULE5 - default: rising write edge, rising read edge
// RULE6 - read inverted: rising write, falling read
// RULE7 - write inverted: falling write, rising read
// RULE8 - both inverted: falling write, falling read
// RULE9 - data and addresses registered at array input
// RULE10 - write needs write enable and clock qualify
// RULE11 - read needs read enable and clock qualify
// RULE12 - contents preloaded before user operation starts
// RULE13 - rom use: user keeps write controls inactive
// RULE14 - user may cascade blocks with external decode
// RULE15 - read data changes only on qualified read
// RULE16 - same address read and write gives undefined data
package br4k_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int ROWS = 256;
    localparam int ROW_W = 8;
    localparam int MEM_BITS = 4096;
    localparam logic [7:0] INIT_LAST = 8'hff;
    localparam logic [DATA_W-1:0] RD_DATA_RST = 16'h0000;

    // array shape, selects port widths
    typedef enum logic [1:0] {
        SHAPE_X16 = 2'b00,
        SHAPE_X8 = 2'b01,
        SHAPE_X4 = 2'b10,
        SHAPE_X2 = 2'b11
    } br4k_shape_t;

    // active edge variant of the two port clocks
    typedef enum logic [1:0] {
        EDGE_RISING = 2'b00,
        EDGE_RD_INVERTED = 2'b01,
        EDGE_WR_INVERTED = 2'b10,
        EDGE_BOTH_INVERTED = 2'b11
    } br4k_edge_t;

    // preload sweep state
    typedef enum logic {
        INIT_SWEEP = 1'b0,
        INIT_DONE = 1'b1
    } br4k_init_t;
endpackage : br4k_pkg

/* File: bench/br4k_user.sv */
// user-logic model that makes the two port clocks of the block ram
`timescale 1ns/100ps
module br4k_user (
    input wire logic wr_inv,
    input wire logic rd_inv,
    input wire logic rom_mode,
    input wire logic wr_req,
    input wire logic rd_req,
    output logic wr_clk,
    output logic rd_clk
);
    // idle level is the inactive one; rom use never pulses the write clock
    assign wr_clk = wr_inv ^ (wr_req & ~rom_mode);
    assign rd_clk = rd_inv ^ rd_req;
endmodule : br4k_user

/* File: bench/tb_top.sv */
// self-checking bench for the 4 kbit block ram
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, rom_mode = 1'b0;
    logic [1:0] ram_shape = 2'b00, edge_mode = 2'b00;
    logic wr_clk, wr_clk_qualify = 1'b0, wr_allow = 1'b0, wr_req = 1'b0;
    logic rd_clk, rd_clk_qualify = 1'b0, rd_allow = 1'b0, rd_req = 1'b0;
    logic [10:0] wr_location = 11'h000, rd_location = 11'h000, top;
    logic [15:0] wr_data = 16'h0000, wr_mask = 16'h0000, rd_data;
    logic init_done;
    int errors = 0, cmp_count = 0, m, s, i;

    // 250 MHz system clock
    always #2 sys_clk = ~sys_clk;

    br4k_user i_br4k_user (.wr_inv(edge_mode[1]), .rd_inv(edge_mode[0]),
        .rom_mode(rom_mode), .wr_req(wr_req), .rd_req(rd_req),
        .wr_clk(wr_clk), .rd_clk(rd_clk));

    br4k_ram #(.INIT_CONTENT(4096'h1234 << 80)) i_br4k_ram (
        .sys_clk(sys_clk), .rst_n(rst_n), .ram_shape(ram_shape),
        .edge_mode(edge_mode), .wr_clk(wr_clk),
        .wr_clk_qualify(wr_clk_qualify), .wr_allow(wr_allow),
        .wr_location(wr_location), .wr_data(wr_data), .wr_mask(wr_mask),
        .rd_clk(rd_clk), .rd_clk_qualify(rd_clk_qualify),
        .rd_allow(rd_allow), .rd_location(rd_location), .rd_data(rd_data),
        .init_done(init_done));

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // one write pulse; data flips before the inactive edge to catch it
    task automatic wr(input logic [10:0] a, input logic [15:0] d,
                      input logic [15:0] mk, input logic we, input logic ce);
        wr_location <= a;
        wr_data <= d;
        wr_mask <= mk;
        wr_allow <= we;
        wr_clk_qualify <= ce;
        cyc(4);
        wr_req <= 1'b1;
        cyc(4);
        wr_data <= ~d;
        cyc(4);
        wr_req <= 1'b0;
        cyc(4);
        wr_allow <= 1'b0;
        wr_clk_qualify <= 1'b0;
        cyc(2);
    endtask : wr

    // one read pulse; address flips before the inactive edge to catch it
    // reads never overlap a write in time
    task automatic rd(input logic [10:0] a, input logic re, input logic ce);
        rd_location <= a;
        rd_allow <= re;
        rd_clk_qualify <= ce;
        cyc(4);
        rd_req <= 1'b1;
        cyc(4);
        rd_location <= ~a;
        cyc(4);
        rd_req <= 1'b0;
        cyc(4);
        rd_allow <= 1'b0;
        rd_clk_qualify <= 1'b0;
        cyc(2);
    endtask : rd

    task automatic rdchk(input string name, input logic [10:0] a,
                         input logic [15:0] exp);
        rd(a, 1'b1, 1'b1);
        check(name, rd_data, exp);
    endtask : rdchk

    // main sequence
    initial begin
        cyc(4);
        check("rd_data_in_reset", rd_data, 16'h0000);
        check("init_in_reset", {15'h0000, init_done}, 16'h0000);
        cyc(1);
        rst_n <= 1'b1;
        for (i = 0; i < 400 && init_done !== 1'b1; i++) cyc(1);
        if (init_done !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        cyc(3);
        rdchk("preload", 11'h005, 16'h1234);
        wr(11'h003, 16'hffff, 16'h0000, 1'b1, 1'b1);
        wr(11'h003, 16'h0000, 16'h00ff, 1'b1, 1'b1);
        rdchk("mask", 11'h003, 16'h00ff);
        wr(11'h003, 16'h5555, 16'h0000, 1'b0, 1'b1);
        wr(11'h003, 16'h5555, 16'h0000, 1'b1, 1'b0);
        rdchk("write_gated", 11'h003, 16'h00ff);
        rdchk("other_row", 11'h005, 16'h1234);
        rd(11'h003, 1'b0, 1'b1);
        check("read_gated_allow", rd_data, 16'h1234);
        rd(11'h003, 1'b1, 1'b0);
        check("read_gated_clk", rd_data, 16'h1234);
        wr(11'h703, 16'hbeef, 16'h0000, 1'b1, 1'b1);
        // unused upper address bits are free for an outside bank decoder
        rdchk("upper_addr", 11'h003, 16'hbeef);
        rom_mode <= 1'b1;
        wr(11'h005, 16'h0bad, 16'h0000, 1'b1, 1'b1);
        rom_mode <= 1'b0;
        rdchk("rom_use", 11'h005, 16'h1234);
        // every edge variant, write then read back
        for (m = 0; m < 4; m++) begin
            edge_mode <= m[1:0];
            cyc(6);
            wr(11'h010 + 11'(m), 16'ha500 + 16'(m), 16'h0000, 1'b1, 1'b1);
            rdchk("edge", 11'h010 + 11'(m),
                  16'ha500 + 16'(m));
        end
        edge_mode <= 2'b00;
        cyc(6);
        // narrow shapes at the top and bottom address, mask ignored
        for (s = 1; s < 4; s++) begin
            ram_shape <= s[1:0];
            cyc(6);
            top = 11'((1 << (8 + s)) - 1);
            wr(top, 16'hffff, 16'hffff, 1'b1, 1'b1);
            wr(11'h000, 16'h0000, 16'h0000, 1'b1, 1'b1);
            rdchk("shape_top", top,
                  16'hffff >> (16 - (16 >> s)));
            rdchk("shape_low", 11'h000, 16'h0000);
        end
        report_and_stop();
    end
endmodule : tb_top
